// File: logic/prtd_core.sv
// command interpreter for raster function, line texture and register dump
`default_nettype none
module prtd_core
  import prtd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // command word stream fetched from the list
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  output logic cmd_ready,
  output logic list_end,
  // register load port from the rest of the engine
  input wire logic reg_wr_en,
  input wire logic [8:0] reg_wr_id,
  input wire logic [21:0] reg_wr_data,
  // colours from the colour definition logic
  input wire logic [15:0] fg_color,
  input wire logic [15:0] bg_color,
  // pixel update path
  input wire logic pix_valid,
  input wire prtd_pix_req_t pix_req,
  output logic pix_out_valid,
  output logic pix_out_write,
  output logic [15:0] pix_out_data,
  // dump memory write port
  output logic mem_wr_valid,
  output prtd_mem_wr_t mem_wr,
  input wire logic mem_wr_ready
);

  typedef enum {S_OP, S_MASK, S_FCODE, S_PAT, S_ALO, S_AHI, S_RID, S_WR1, S_WR2} prtd_state_t;

  // identifier to storage slot; slot NUM_REGS means unknown
  function automatic logic [4:0] id_slot(input logic [8:0] id);
    logic [4:0] s;
    s = 5'(NUM_REGS);
    if (id == ID_POLL_MASK) s = 5'd0;
    else if (id == ID_INT_MASK) s = 5'd1;
    else if (id == ID_CTX_FIVE) s = 5'd2;
    else if (id == ID_CTX_NINE) s = 5'd3;
    else if (id == ID_CTX_TEN) s = 5'd4;
    else if (id == ID_CTX_ELEVEN) s = 5'd5;
    else if (id == ID_CTX_TWELVE) s = 5'd6;
    else if (id == ID_CHAR_COUNT) s = 5'd7;
    else if (id == ID_CTX_THIRTEEN) s = 5'd8;
    else if (id == ID_CTX_FOURTEEN) s = 5'd9;
    else if (id == ID_CTX_SIXTEEN) s = 5'd10;
    else if (id == ID_CTX_SEVENTEEN) s = 5'd11;
    else if (id == ID_CTX_EIGHTEEN) s = 5'd12;
    else if (id == ID_CTX_NINETEEN) s = 5'd13;
    else if (id == ID_CTX_TWENTY) s = 5'd14;
    else if (id == ID_CTX_TWENTYONE) s = 5'd15;
    else if (id == ID_CTX_TWENTYTWO) s = 5'd16;
    else if (id == ID_CTX_SIX) s = 5'd17;
    else if (id == ID_STACK_PTR) s = 5'd18;
    else if (id == ID_CTX_SEVEN) s = 5'd19;
    else if (id == ID_CTX_EIGHT) s = 5'd20;
    return s;
  endfunction : id_slot

  // mask of the bits a register really holds
  function automatic logic [21:0] id_bits(input logic [8:0] id);
    logic [21:0] m;
    m = 22'h00ffff;
    if (id == ID_POLL_MASK) m = 22'h00003f;
    else if (id == ID_INT_MASK) m = 22'h0000ff;
    else if (id == ID_CTX_FIVE || id == ID_CTX_FOURTEEN) m = 22'h00000f;
    else if (id == ID_STACK_PTR) m = 22'h3fffff;
    else if (id == ID_CTX_SIX || id == ID_CTX_SEVEN || id == ID_CTX_EIGHT) m = 22'h1fffff;
    else if (id_slot(id) == 5'(NUM_REGS)) m = 22'h000000;
    return m;
  endfunction : id_bits

  // command state
  prtd_state_t state_q, state_d;
  logic [15:0] mask_q;
  logic [3:0] fcode_q;
  logic [15:0] texture_q;
  logic tex_transp_q;
  logic end_flag_q;
  logic [15:0] addr_lo_q;
  logic [21:0] dump_val_q;
  logic dump_wide_q;
  logic [21:0] regs_q [0:NUM_REGS-1];
  logic cmd_ready_q, list_end_q;
  logic mem_wr_valid_q;
  prtd_mem_wr_t mem_wr_q;

  wire logic take = cmd_valid && cmd_ready_q;
  wire logic [7:0] opcode = cmd_word[OPC_MSB:OPC_LSB];
  wire logic mem_done = mem_wr_valid_q && mem_wr_ready;

  // dump value lookup for the identifier word being taken
  wire logic [8:0] rid = cmd_word[REG_ID_BITS-1:0];
  wire logic [4:0] rslot = id_slot(rid);
  wire logic [21:0] rraw = (rslot == 5'(NUM_REGS)) ? 22'h000000 : regs_q[rslot];
  wire logic [21:0] rbits = id_bits(rid);
  wire logic [21:0] rmasked = rraw & rbits;
  wire logic [21:0] rval = (rid == ID_CTX_FIVE) ?
                           {12'h000, rmasked[3:2], 6'h00, rmasked[1:0]} : rmasked;
  // wide when bits above sixteen exist
  wire logic rwide = |rbits[21:16];

  // next state of the command sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_OP: begin
        if (take) begin
          if (opcode == OP_SET_RASTER_FN) state_d = S_MASK;
          else if (opcode == OP_TEX_OPAQUE || opcode == OP_TEX_TRANSP) state_d = S_PAT;
          else if (opcode == OP_DUMP_REG) state_d = S_ALO;
        end
      end
      S_MASK: if (take) state_d = S_FCODE;
      S_FCODE: if (take) state_d = S_OP;
      S_PAT: if (take) state_d = S_OP;
      S_ALO: if (take) state_d = S_AHI;
      S_AHI: if (take) state_d = S_RID;
      S_RID: if (take) state_d = S_WR1;
      S_WR1: if (mem_done) state_d = dump_wide_q ? S_WR2 : S_OP;
      S_WR2: if (mem_done) state_d = S_OP;
      default: state_d = S_OP;
    endcase
  end

  // a command is finished when its last word is taken or its last write lands
  wire logic single_done = take && state_q == S_OP && state_d == S_OP;
  wire logic cmd_done = single_done || (take && (state_q == S_FCODE || state_q == S_PAT)) ||
                        (mem_done && state_d == S_OP);
  wire logic done_end = single_done ? cmd_word[END_FLAG_BIT] : end_flag_q;

  // sequencer and handshake registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_OP;
      cmd_ready_q <= 1'b0;
      list_end_q <= 1'b0;
      end_flag_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // ready is withheld while the dump writes are pending
      cmd_ready_q <= !(state_d == S_WR1 || state_d == S_WR2);
      list_end_q <= cmd_done && done_end;
      if (take && state_q == S_OP) end_flag_q <= cmd_word[END_FLAG_BIT];
    end
  end

  // raster function and texture settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= RST_MASK;
      fcode_q <= RST_FCODE;
      texture_q <= RST_TEXTURE;
      tex_transp_q <= 1'b0;
    end else begin
      if (take && state_q == S_MASK) mask_q <= cmd_word;
      // only the low nibble is the code
      if (take && state_q == S_FCODE) fcode_q <= cmd_word[3:0];
      if (take && state_q == S_OP && (opcode == OP_TEX_OPAQUE || opcode == OP_TEX_TRANSP))
        tex_transp_q <= cmd_word[TEX_MODE_BIT];
      if (take && state_q == S_PAT) texture_q <= cmd_word;
    end
  end

  // dump address, value capture and the memory write port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_lo_q <= 16'h0000;
      dump_val_q <= 22'h000000;
      dump_wide_q <= 1'b0;
      mem_wr_valid_q <= 1'b0;
      mem_wr_q <= '0;
    end else begin
      if (take && state_q == S_ALO) addr_lo_q <= cmd_word;
      if (take && state_q == S_AHI) mem_wr_q.addr <= {cmd_word[ADDR_HI_BITS-1:0], addr_lo_q};
      // first word goes out once the identifier is known
      if (take && state_q == S_RID) begin
        dump_val_q <= rval;
        dump_wide_q <= rwide;
        // low word, right-justified except the ID_CTX_FIVE pairs at 9:8 and 1:0, unused bits zero
        mem_wr_q.data <= rval[15:0];
        mem_wr_valid_q <= 1'b1;
      end else if (mem_done && state_q == S_WR1 && dump_wide_q) begin
        // remaining bits in the next word
        mem_wr_q.addr <= mem_wr_q.addr + DUMP_STEP;
        mem_wr_q.data <= {10'h000, dump_val_q[21:16]};
      end else if (mem_done) begin
        mem_wr_valid_q <= 1'b0;
      end
    end
  end

  // register storage, loaded by the engine, trimmed to each register's width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= 22'h000000;
    end else if (reg_wr_en && id_slot(reg_wr_id) != 5'(NUM_REGS)) begin
      regs_q[id_slot(reg_wr_id)] <= reg_wr_data & id_bits(reg_wr_id);
    end
  end

  // texture bit pointer: a start request restarts at the msb
  logic [3:0] tex_idx_q;
  wire logic geom_pix = pix_valid && pix_req.kind == PK_GEOM;
  wire logic [3:0] tex_idx_use = pix_req.geom_start ? TEX_FIRST_IDX : tex_idx_q;
  wire logic tex_bit = texture_q[tex_idx_use];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tex_idx_q <= TEX_FIRST_IDX;
    else if (geom_pix) tex_idx_q <= tex_idx_use - 4'h1;
  end

  wire logic pat_bit = (pix_req.kind == PK_GEOM) ? tex_bit : pix_req.font_bit;
  wire logic pat_transp = (pix_req.kind == PK_GEOM) ? tex_transp_q : pix_req.char_transp;
  // foreground for one bits, background for opaque zero bits
  wire logic [15:0] src = (pix_req.kind == PK_BLIT) ? pix_req.blit_src :
                          (pat_bit ? fg_color : bg_color);
  wire logic skip = pix_req.kind != PK_BLIT && pat_transp && !pat_bit;

  // truth-table lookup, msb is dest 0 source 0
  function automatic logic rop_bit(input logic [3:0] fc, input logic d, input logic s);
    return fc[~{d, s}];
  endfunction : rop_bit

  // per-bit function against the stored destination
  logic [15:0] rop_res;
  always_comb begin
    rop_res = 16'h0000;
    for (int b = 0; b < 16; b++) rop_res[b] = rop_bit(fcode_q, pix_req.dst[b], src[b]);
  end
  wire logic [15:0] pix_new = (rop_res & mask_q) | (pix_req.dst & ~mask_q);
  // reference result as a sum of products, kept apart from the lookup so checks compare two forms
  wire logic [15:0] rop_ref = ({16{fcode_q[3]}} & ~pix_req.dst & ~src) |
                              ({16{fcode_q[2]}} & ~pix_req.dst & src) |
                              ({16{fcode_q[1]}} & pix_req.dst & ~src) |
                              ({16{fcode_q[0]}} & pix_req.dst & src);

  // registered pixel result; a skipped pixel returns its old value with write low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_out_valid <= 1'b0;
      pix_out_write <= 1'b0;
      pix_out_data <= 16'h0000;
    end else begin
      pix_out_valid <= pix_valid;
      pix_out_write <= pix_valid && !skip;
      pix_out_data <= skip ? pix_req.dst : pix_new;
    end
  end

  assign cmd_ready = cmd_ready_q;
  assign list_end = list_end_q;
  assign mem_wr_valid = mem_wr_valid_q;
  assign mem_wr = mem_wr_q;

  // checks; the raster function steps and the dump id step are named sequences, used by all their properties except p_pairs
  sequence s_fn_op;
    take && state_q == S_OP && opcode == OP_SET_RASTER_FN;
  endsequence
  sequence s_fn_mask;
    take && state_q == S_MASK;
  endsequence
  sequence s_fn_code;
    take && state_q == S_FCODE;
  endsequence
  sequence s_dump_id;
    take && state_q == S_RID;
  endsequence
  property p_fn_op;
    @(posedge clk) disable iff (!rst_n)
      s_fn_op |=> state_q == S_MASK;
  endproperty
  a_fn_op: assert property (p_fn_op) else $error("mask step not entered");
  property p_mask_latch;
    @(posedge clk) disable iff (!rst_n)
      s_fn_mask |=> mask_q == $past(cmd_word) && state_q == S_FCODE;
  endproperty
  a_mask_latch: assert property (p_mask_latch) else $error("colour mask not latched");
  property p_fn_seq;
    @(posedge clk) disable iff (!rst_n)
      s_fn_code |=> fcode_q == $past(cmd_word[3:0]) && state_q == S_OP;
  endproperty
  a_fn_seq: assert property (p_fn_seq) else $error("function code not latched");
  property p_rop;
    @(posedge clk) disable iff (!rst_n)
      pix_valid && !skip |=> pix_out_write &&
        pix_out_data == (($past(pix_req.dst) & ~$past(mask_q)) | ($past(mask_q) & $past(rop_ref)));
  endproperty
  a_rop: assert property (p_rop) else $error("raster function result wrong");
  property p_mask_keep;
    @(posedge clk) disable iff (!rst_n)
      pix_valid |=> ((pix_out_data ^ $past(pix_req.dst)) & ~$past(mask_q)) == 16'h0000;
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("masked bit changed");
  property p_transp_skip;
    @(posedge clk) disable iff (!rst_n)
      geom_pix && tex_transp_q && !tex_bit |=> pix_out_valid && !pix_out_write;
  endproperty
  a_transp_skip: assert property (p_transp_skip) else $error("transparent pixel written");
  property p_tex_mode;
    @(posedge clk) disable iff (!rst_n)
      take && state_q == S_OP && opcode == OP_TEX_TRANSP |=> tex_transp_q;
  endproperty
  a_tex_mode: assert property (p_tex_mode) else $error("texture mode not transparent");
  property p_tex_latch;
    @(posedge clk) disable iff (!rst_n)
      take && state_q == S_PAT |=> texture_q == $past(cmd_word) && state_q == S_OP;
  endproperty
  a_tex_latch: assert property (p_tex_latch) else $error("texture pattern not latched");
  property p_opaque;
    @(posedge clk) disable iff (!rst_n)
      geom_pix && !tex_transp_q |=> pix_out_valid && pix_out_write;
  endproperty
  a_opaque: assert property (p_opaque) else $error("opaque pixel not written");
  property p_msb_first;
    @(posedge clk) disable iff (!rst_n)
      geom_pix && pix_req.geom_start |=> tex_idx_q == 4'he;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("texture not started at msb");
  property p_narrow;
    @(posedge clk) disable iff (!rst_n)
      s_dump_id ##0 !rwide |=> mem_wr_valid && mem_wr.data == $past(rval[15:0]);
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow dump word wrong");
  property p_narrow_end;
    @(posedge clk) disable iff (!rst_n)
      mem_done && state_q == S_WR1 && !dump_wide_q |=> !mem_wr_valid && state_q == S_OP;
  endproperty
  a_narrow_end: assert property (p_narrow_end) else $error("narrow dump not ended");
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr);
  endproperty
  a_hold: assert property (p_hold) else $error("dump word dropped before taken");
  property p_busy;
    @(posedge clk) disable iff (!rst_n)
      s_dump_id |=> !cmd_ready && mem_wr_valid;
  endproperty
  a_busy: assert property (p_busy) else $error("command taken during dump");
  property p_wide_second;
    @(posedge clk) disable iff (!rst_n)
      mem_done && state_q == S_WR1 && dump_wide_q |=>
        mem_wr_valid && mem_wr.addr == $past(mem_wr.addr) + DUMP_STEP &&
        mem_wr.data[15:6] == 10'h000;
  endproperty
  a_wide_second: assert property (p_wide_second) else $error("second dump word wrong");
  property p_pairs;
    @(posedge clk) disable iff (!rst_n)
      take && state_q == S_RID && rid == ID_CTX_FIVE |=> (mem_wr.data & 16'hfcfc) == 16'h0000;
  endproperty
  a_pairs: assert property (p_pairs) else $error("pair register layout wrong");

endmodule : prtd_core
`default_nettype wire

// File: logic/prtd_pkg.sv
// constants and carrier types for the raster function, texture and dump command logic
`default_nettype none
package prtd_pkg;
  // command opcodes, taken from bits 15:8 of the first word
  localparam logic [7:0] OP_SET_RASTER_FN = 8'h41;
  localparam logic [7:0] OP_TEX_OPAQUE = 8'h06;
  localparam logic [7:0] OP_TEX_TRANSP = 8'h07;
  localparam logic [7:0] OP_DUMP_REG = 8'h29;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 8;
  localparam int END_FLAG_BIT = 0;
  localparam int TEX_MODE_BIT = 8;
  localparam int ADDR_HI_BITS = 6;
  localparam int REG_ID_BITS = 9;
  localparam int REG_W = 22;
  localparam int NUM_REGS = 21;
  // register identifiers as seen by the dump command
  localparam logic [8:0] ID_POLL_MASK = 9'h003;
  localparam logic [8:0] ID_INT_MASK = 9'h004;
  localparam logic [8:0] ID_CTX_FIVE = 9'h007;
  localparam logic [8:0] ID_CTX_NINE = 9'h010;
  localparam logic [8:0] ID_CTX_TEN = 9'h011;
  localparam logic [8:0] ID_CTX_ELEVEN = 9'h012;
  localparam logic [8:0] ID_CTX_TWELVE = 9'h013;
  localparam logic [8:0] ID_CHAR_COUNT = 9'h015;
  localparam logic [8:0] ID_CTX_THIRTEEN = 9'h016;
  localparam logic [8:0] ID_CTX_FOURTEEN = 9'h01c;
  localparam logic [8:0] ID_CTX_SIXTEEN = 9'h090;
  localparam logic [8:0] ID_CTX_SEVENTEEN = 9'h091;
  localparam logic [8:0] ID_CTX_EIGHTEEN = 9'h096;
  localparam logic [8:0] ID_CTX_NINETEEN = 9'h097;
  localparam logic [8:0] ID_CTX_TWENTY = 9'h099;
  localparam logic [8:0] ID_CTX_TWENTYONE = 9'h09b;
  localparam logic [8:0] ID_CTX_TWENTYTWO = 9'h09c;
  localparam logic [8:0] ID_CTX_SIX = 9'h10b;
  localparam logic [8:0] ID_STACK_PTR = 9'h10c;
  localparam logic [8:0] ID_CTX_SEVEN = 9'h10d;
  localparam logic [8:0] ID_CTX_EIGHT = 9'h10f;
  // reset values of held state, and the dump address step
  localparam logic [15:0] RST_MASK = 16'hffff;
  localparam logic [3:0] RST_FCODE = 4'h5;
  localparam logic [15:0] RST_TEXTURE = 16'hffff;
  localparam logic [3:0] TEX_FIRST_IDX = 4'hf;
  localparam logic [21:0] DUMP_STEP = 22'h000002;
  // pixel source kinds
  typedef enum logic [1:0] {PK_GEOM, PK_CHAR, PK_BLIT} prtd_kind_t;
  // one pixel update request from the drawing engine
  typedef struct packed {
    prtd_kind_t kind;
    logic geom_start;
    logic font_bit;
    logic char_transp;
    logic [15:0] blit_src;
    logic [15:0] dst;
  } prtd_pix_req_t;
  // one memory word write of the dump command
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } prtd_mem_wr_t;
endpackage : prtd_pkg
`default_nettype wire

// File: tb/prtd_mem_model.sv
// memory model that takes the dump words, answering promptly or slowly
`default_nettype none
module prtd_mem_model
  import prtd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mem_wr_valid,
  input wire prtd_mem_wr_t mem_wr,
  output logic mem_wr_ready,
  output var int n_wr,
  output prtd_mem_wr_t prev_wr,
  output prtd_mem_wr_t last_wr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] gap_q;
  // slow mode opens the port one cycle in three so the dump must hold its word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 2'h0;
      mem_wr_ready <= 1'b0;
    end else begin
      gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
      mem_wr_ready <= !slow || (gap_q == 2'h1);
    end
  end
  // keep the two most recent accepted words for the bench to judge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_wr <= 0;
      prev_wr <= '0;
      last_wr <= '0;
    end else if (mem_wr_valid && mem_wr_ready) begin
      n_wr <= n_wr + 1;
      prev_wr <= last_wr;
      last_wr <= mem_wr;
    end
  end
endmodule : prtd_mem_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the raster function, texture and dump command logic
`default_nettype none
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module testbench
  import prtd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  logic reg_wr_en = 1'b0;
  logic [8:0] reg_wr_id = 9'h000;
  logic [21:0] reg_wr_data = 22'h000000;
  logic [15:0] fg_color = 16'haaaa;
  logic [15:0] bg_color = 16'h5555;
  logic pix_valid = 1'b0;
  prtd_pix_req_t pix_req = '0;
  logic slow = 1'b0;
  logic cmd_ready, list_end, pix_out_valid, pix_out_write, mem_wr_valid, mem_wr_ready;
  logic [15:0] pix_out_data;
  prtd_mem_wr_t mem_wr, prev_wr, last_wr;
  int n_wr;
  int n_fail = 0;
  int checks = 0;

  // clock of 4 ns
  always #2 clk = ~clk;

  prtd_core dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready), .list_end(list_end), .reg_wr_en(reg_wr_en), .reg_wr_id(reg_wr_id),
    .reg_wr_data(reg_wr_data), .fg_color(fg_color), .bg_color(bg_color),
    .pix_valid(pix_valid), .pix_req(pix_req), .pix_out_valid(pix_out_valid),
    .pix_out_write(pix_out_write), .pix_out_data(pix_out_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready));

  prtd_mem_model mem (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_wr_valid(mem_wr_valid),
    .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready), .n_wr(n_wr), .prev_wr(prev_wr),
    .last_wr(last_wr));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // offer one word and hold it until ready was high at the taking edge
  task automatic send_word(input logic [15:0] w);
    logic r;
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_word = w;
    for (n = 0; n < 100; n++) begin
      r = cmd_ready;
      @(posedge clk);
      if (r) break;
      @(negedge clk);
    end
  endtask : send_word

  // release the stream and look for the end pulse in a short window
  task automatic end_seen(input logic exp);
    logic s;
    s = 1'b0;
    repeat (5) begin
      @(negedge clk);
      cmd_valid = 1'b0;
      s = s | list_end;
    end
    `CHK("list_end", exp, s);
  endtask : end_seen

  function automatic logic [15:0] rop(input logic [3:0] fc, input logic [15:0] m, s, d);
    int i;
    for (i = 0; i < 16; i++) rop[i] = m[i] ? fc[3 - {d[i], s[i]}] : d[i];
  endfunction : rop

  function automatic int wid(input logic [8:0] id);
    case (id)
      ID_POLL_MASK: wid = 6;
      ID_INT_MASK: wid = 8;
      ID_CTX_FIVE, ID_CTX_FOURTEEN: wid = 4;
      ID_CTX_SIX, ID_CTX_SEVEN, ID_CTX_EIGHT: wid = 21;
      ID_STACK_PTR: wid = 22;
      9'h1ff: wid = 0;
      default: wid = 16;
    endcase
  endfunction : wid

  task automatic set_rop(input logic [15:0] m, input logic [3:0] fc, input logic fl);
    send_word({OP_SET_RASTER_FN, 7'h00, fl});
    send_word(m);
    send_word({12'h000, fc});
    end_seen(fl);
  endtask : set_rop

  // one pixel request, judged on the cycle its answer stands
  task automatic pix(input prtd_kind_t k, input logic st, fb, ct, input logic [15:0] src, dst,
                     input logic ew, input logic [15:0] ed);
    @(negedge clk);
    pix_valid = 1'b1;
    pix_req = '{k, st, fb, ct, src, dst};
    @(negedge clk);
    pix_valid = 1'b0;
    `CHK("pix_out_valid", 1'b1, pix_out_valid);
    `CHK("pix_out_write", ew, pix_out_write);
    `CHK("pix_out_data", ed, pix_out_data);
  endtask : pix

  task automatic t_reset();
    repeat (2) @(negedge clk);
    `CHK("cmd_ready", 1'b1, cmd_ready);
    `CHK("mem_wr_valid", 1'b0, mem_wr_valid);
    pix(PK_BLIT, 1'b0, 1'b0, 1'b0, 16'h3c96, 16'h0ff0, 1'b1, 16'h3c96);
  endtask : t_reset

  // every function code under a replicated two-bit mask
  task automatic t_rop();
    int f;
    for (f = 0; f < 16; f++) begin
      // mask 01 repeated over the word
      set_rop(16'h5555, 4'(f), f[0]);
      pix(PK_BLIT, 1'b0, 1'b0, 1'b0, 16'h00ff, 16'h0f0f, 1'b1,
          rop(4'(f), 16'h5555, 16'h00ff, 16'h0f0f));
    end
  endtask : t_rop

  task automatic t_tex();
    logic [15:0] p;
    logic b;
    int k, m;
    p = 16'hb38d;
    set_rop(16'hffff, 4'h5, 1'b0);
    for (m = 0; m < 2; m++) begin
      send_word({m ? OP_TEX_TRANSP : OP_TEX_OPAQUE, 8'h00});
      send_word(p);
      end_seen(1'b0);
      for (k = 0; k < 20; k++) begin
        b = p[15 - (k < 9 ? k : k - 9)];
        // start and restart at the top bit
        pix(PK_GEOM, k == 0 || k == 9, 1'b0, 1'b0, 16'h0000, 16'h0ff0,
            m ? b : 1'b1, b ? fg_color : (m ? 16'h0ff0 : bg_color));
      end
      pix(PK_BLIT, 1'b0, 1'b0, 1'b0, 16'h1234, 16'h0ff0, 1'b1, 16'h1234);
      pix(PK_CHAR, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0ff0, 1'b0, 16'h0ff0);
      pix(PK_CHAR, 1'b0, 1'b1, 1'b1, 16'h0000, 16'h0ff0, 1'b1, fg_color);
      pix(PK_CHAR, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0ff0, 1'b1, bg_color);
    end
  endtask : t_tex

  task automatic t_dump();
    logic [8:0] ids [9];
    logic [21:0] v, t, a;
    logic [15:0] e;
    int i, n, n0;
    ids = '{ID_POLL_MASK, ID_INT_MASK, ID_CHAR_COUNT, ID_STACK_PTR, ID_CTX_FIVE,
            ID_CTX_SIX, ID_CTX_FOURTEEN, ID_CTX_TWENTYTWO, 9'h1ff};
    for (i = 0; i < 9; i++) begin
      v = 22'h3c5a69 + 22'(i);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_wr_id = ids[i];
      reg_wr_data = v;
      @(negedge clk);
      reg_wr_en = 1'b0;
      t = v & ((22'h1 << wid(ids[i])) - 22'h1);
      a = {6'h2a, 16'h1230 + 16'(i * 8)};
      slow = i[0];
      n0 = n_wr;
      // even address, control and context ids plus one unknown id
      send_word({OP_DUMP_REG, 8'h00});
      send_word(a[15:0]);
      send_word({10'h000, a[21:16]});
      send_word({7'h00, ids[i]});
      // release right after the id word is taken, so it is never offered twice
      @(negedge clk);
      cmd_valid = 1'b0;
      for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clk);
      e = (ids[i] == ID_CTX_FIVE) ? {6'h00, t[3:2], 6'h00, t[1:0]} : t[15:0];
      if (wid(ids[i]) > 16) begin
        `CHK("dump words", n0 + 2, n_wr);
        `CHK("low addr", a, prev_wr.addr);
        `CHK("low data", e, prev_wr.data);
        `CHK("high addr", a + 22'h2, last_wr.addr);
        `CHK("high data", {10'h000, t[21:16]}, last_wr.data);
      end else begin
        `CHK("dump words", n0 + 1, n_wr);
        `CHK("dump addr", a, last_wr.addr);
        `CHK("dump data", e, last_wr.data);
      end
    end
  endtask : t_dump

  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_rop();
    t_tex();
    t_dump();
    wrap_up();
  end

  // watchdog at 10000 cycles, well beyond the few hundred cycles the scenarios need
  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
